// [rtl/hpp_addr_latch.sv]
`timescale 1ns/1ns
`default_nettype none
`include "hpp_cfg.svh"

module hpp_addr_latch #(
    parameter int ADDR_W = `HPP_ADDR_W,
    parameter int DATA_W = `HPP_DATA_W
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic enable_i,
    input wire logic strobe_i,
    input wire logic [DATA_W-1:0] lines_i,
    output logic [ADDR_W-1:0] addr_o,
    output logic strobe_fall_o
);

    ////////////////////////////////////////////////////////////////////
    logic strobe_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    wire strobe_fall;

    // Strobe is ignored outside the multiplexed mode
    assign strobe_fall = enable_i & strobe_reg & ~strobe_i;
    assign addr_next = strobe_fall ?
        {{(ADDR_W-DATA_W){1'b0}}, lines_i} : addr_reg;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strobe_reg <= 1'b0;
            addr_reg <= `HPP_ADDR_RST;
        end else begin
            strobe_reg <= strobe_i;
            addr_reg <= addr_next;
        end
    end

    assign addr_o = addr_reg;
    assign strobe_fall_o = strobe_fall;

endmodule

`default_nettype wire

// [rtl/hpp_cfg.svh]
`ifndef HPP_CFG_SVH
`define HPP_CFG_SVH

// Bus widths
`define HPP_ADDR_W 10
`define HPP_DATA_W 8

// Reset values
`define HPP_ADDR_RST 10'h000
`define HPP_DATA_RST 8'h00
`define HPP_LAT_RST 4'h0

// Cycles from the memory read pulse to valid read data
`define HPP_READ_LAT 4'h1

// Strap level that selects the multiplexed bus
`define HPP_MUX_LEVEL 1'b1

`endif

// [rtl/hpp_host_port.sv]
// Behaviour
// - High strap selects the multiplexed bus, low the separate address bus.
// - The latch strobe is used only in multiplexed mode.
// - Multiplexed mode takes the address from the shared lines first.
// - The shared lines carry data between the host and internal memories.
// - Transfer acknowledge is pulled low on completion, released otherwise.
// - Interrupt request is pulled low only for a flagged and enabled source.
// - Data strobes are ignored while the active-low chip select is high; the address latch strobe is not.
// - In separate mode the ten dedicated address inputs pick the location.
// - With a direction input, reads drive the lines and writes accept them.
// - With separate strobes, read strobe drives and write strobe accepts.
`timescale 1ns/1ns
`default_nettype none
`include "hpp_cfg.svh"

module hpp_host_port #(
    parameter int ADDR_W = `HPP_ADDR_W,
    parameter int DATA_W = `HPP_DATA_W,
    parameter logic [3:0] READ_LAT = `HPP_READ_LAT
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic BUS_STYLE_STRAP_I,
    input wire logic STROBE_STYLE_I,
    input wire logic CHIP_SELECT_N_I,
    input wire logic ADDRESS_LATCH_STROBE_I,
    input wire logic DATA_READ_STROBE_I,
    input wire logic RW_WRITE_I,
    input wire logic [ADDR_W-1:0] DEDICATED_ADDRESS_LINES_I,
    input wire logic [DATA_W-1:0] SHARED_ADDR_DATA_LINES_I,
    output logic [DATA_W-1:0] SHARED_ADDR_DATA_LINES_O,
    output logic SHARED_ADDR_DATA_LINES_OE_N_O,
    output logic TRANSFER_ACK_N_O,
    output logic TRANSFER_ACK_OE_N_O,
    output logic IRQ_N_O,
    output logic IRQ_OE_N_O,
    input wire logic [DATA_W-1:0] INT_STATUS_I,
    input wire logic [DATA_W-1:0] INT_ENABLE_I,
    output logic [ADDR_W-1:0] MEM_ADDR_O,
    output logic [DATA_W-1:0] MEM_WDATA_O,
    output logic MEM_WRITE_O,
    output logic MEM_READ_O,
    input wire logic [DATA_W-1:0] MEM_RDATA_I
);

    ////////////////////////////////////////////////////////////////////
    // Mode and strobe decode

    hpp_pkg::hpp_state_e state_reg;
    hpp_pkg::hpp_state_e state_next;
    logic mux_mode_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic is_read_reg;
    logic write_pulse_reg;
    logic read_pulse_reg;
    logic [3:0] lat_reg;
    logic [3:0] lat_next;
    logic [ADDR_W-1:0] latched_addr;

    wire mux_mode_now;
    wire sep_strobes;
    wire sep_read;
    wire sep_write;
    wire ds_active;
    wire strobe_active;
    wire access_read;
    wire access_on;
    wire start_access;
    wire lat_done;
    wire [ADDR_W-1:0] access_addr;

    // Mode only changes between accesses
    assign mux_mode_now = (BUS_STYLE_STRAP_I == `HPP_MUX_LEVEL);

    // Separate read and write strobes exist only on the multiplexed bus
    assign sep_strobes = mux_mode_reg & STROBE_STYLE_I;
    assign sep_read = ~DATA_READ_STROBE_I;
    assign sep_write = ~RW_WRITE_I;

    // Data strobe is active high when multiplexed, active low otherwise
    assign ds_active = mux_mode_reg ? DATA_READ_STROBE_I
                                    : ~DATA_READ_STROBE_I;

    assign strobe_active = sep_strobes ? (sep_read | sep_write)
                                       : ds_active;
    assign access_read = sep_strobes ? sep_read : RW_WRITE_I;

    // No access starts without chip select; the address latch still runs
    assign access_on = ~CHIP_SELECT_N_I & strobe_active;
    assign start_access = (state_reg == hpp_pkg::HPP_IDLE) & access_on;

    // Address source depends on the bus mode
    assign access_addr = mux_mode_reg ? latched_addr
                                      : DEDICATED_ADDRESS_LINES_I;

    assign lat_done = (lat_reg == `HPP_LAT_RST);

    ////////////////////////////////////////////////////////////////////
    // Address latch

    hpp_addr_latch #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_addr_latch (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .enable_i(mux_mode_reg),
        .strobe_i(ADDRESS_LATCH_STROBE_I),
        .lines_i(SHARED_ADDR_DATA_LINES_I),
        .addr_o(latched_addr),
        .strobe_fall_o()
    );

    ////////////////////////////////////////////////////////////////////
    // Access sequencer

    always_comb begin
        state_next = state_reg;
        lat_next = lat_reg;
        case (state_reg)
            hpp_pkg::HPP_IDLE: begin
                if (access_on) begin
                    state_next = hpp_pkg::HPP_WAIT;
                    lat_next = access_read ? READ_LAT : `HPP_LAT_RST;
                end
            end
            hpp_pkg::HPP_WAIT: begin
                if (!access_on) begin
                    state_next = hpp_pkg::HPP_IDLE;
                end else if (lat_done) begin
                    state_next = hpp_pkg::HPP_ACK;
                end else begin
                    lat_next = lat_reg - 4'h1;
                end
            end
            hpp_pkg::HPP_ACK: begin
                // Hold completion until the host ends the cycle
                if (!access_on) begin
                    state_next = hpp_pkg::HPP_IDLE;
                end
            end
            default: begin
                state_next = hpp_pkg::HPP_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_reg <= hpp_pkg::HPP_IDLE;
            lat_reg <= `HPP_LAT_RST;
        end else begin
            state_reg <= state_next;
            lat_reg <= lat_next;
        end
    end

    // Strap is sampled only while idle
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mux_mode_reg <= 1'b0;
        end else if (state_reg == hpp_pkg::HPP_IDLE && !access_on) begin
            mux_mode_reg <= mux_mode_now;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Memory side

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            addr_reg <= `HPP_ADDR_RST;
            wdata_reg <= `HPP_DATA_RST;
            is_read_reg <= 1'b0;
            write_pulse_reg <= 1'b0;
            read_pulse_reg <= 1'b0;
        end else begin
            write_pulse_reg <= start_access & ~access_read;
            read_pulse_reg <= start_access & access_read;
            if (start_access) begin
                addr_reg <= access_addr;
                wdata_reg <= SHARED_ADDR_DATA_LINES_I;
                is_read_reg <= access_read;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rdata_reg <= `HPP_DATA_RST;
        end else if (state_reg == hpp_pkg::HPP_WAIT && lat_done) begin
            rdata_reg <= MEM_RDATA_I;
        end
    end

    assign MEM_ADDR_O = addr_reg;
    assign MEM_WDATA_O = wdata_reg;
    assign MEM_WRITE_O = write_pulse_reg;
    assign MEM_READ_O = read_pulse_reg;

    ////////////////////////////////////////////////////////////////////
    // Pins toward the host

    // Lines are driven only for a read that has completed
    assign SHARED_ADDR_DATA_LINES_O = rdata_reg;
    assign SHARED_ADDR_DATA_LINES_OE_N_O =
        ~(access_on & is_read_reg &
          (state_reg == hpp_pkg::HPP_ACK));

    assign TRANSFER_ACK_N_O = 1'b0;
    assign TRANSFER_ACK_OE_N_O =
        ~(state_reg == hpp_pkg::HPP_ACK);

    assign IRQ_N_O = 1'b0;
    assign IRQ_OE_N_O = ~(|(INT_STATUS_I & INT_ENABLE_I));

endmodule

`default_nettype wire

// [rtl/hpp_pkg.sv]
package hpp_pkg;

    typedef enum logic [1:0] {
        HPP_IDLE,
        HPP_WAIT,
        HPP_ACK
    } hpp_state_e;

    typedef logic [9:0] hpp_addr_t;
    typedef logic [7:0] hpp_data_t;

endpackage

// [sim/hpp_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module hpp_mem_model (
    input wire logic clk_i,
    input wire logic write_i,
    input wire logic read_i,
    input wire logic [9:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [1024];
    // Read data held until the next read
    always @(posedge clk_i) begin
        if (write_i) mem[addr_i] <= wdata_i;
        if (read_i) rdata_o <= mem[addr_i];
    end
endmodule
`default_nettype wire

// [sim/hpp_port_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module hpp_port_checker (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic BUS_STYLE_STRAP_I,
    input wire logic CHIP_SELECT_N_I,
    input wire logic ADDRESS_LATCH_STROBE_I,
    input wire logic [9:0] DEDICATED_ADDRESS_LINES_I,
    input wire logic [7:0] SHARED_ADDR_DATA_LINES_I,
    input wire logic [7:0] SHARED_ADDR_DATA_LINES_O,
    input wire logic SHARED_ADDR_DATA_LINES_OE_N_O,
    input wire logic TRANSFER_ACK_OE_N_O,
    input wire logic IRQ_OE_N_O,
    input wire logic [7:0] INT_STATUS_I,
    input wire logic [7:0] INT_ENABLE_I,
    input wire logic [9:0] MEM_ADDR_O,
    input wire logic [7:0] MEM_WDATA_O,
    input wire logic MEM_WRITE_O,
    input wire logic MEM_READ_O,
    input wire logic [7:0] MEM_RDATA_I
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    // Reference address latch, taken on the strobe's falling edge
    logic ale_reg;
    logic [7:0] mux_addr_reg;
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ale_reg <= 1'b0;
            mux_addr_reg <= 8'h00;
        end else begin
            ale_reg <= ADDRESS_LATCH_STROBE_I;
            if (ale_reg && !ADDRESS_LATCH_STROBE_I && BUS_STYLE_STRAP_I) begin
                mux_addr_reg <= SHARED_ADDR_DATA_LINES_I;
            end
        end
    end
    irq_gate_a: assert property (
        IRQ_OE_N_O == ~|(INT_STATUS_I & INT_ENABLE_I))
        else $error("irq enable gating wrong");
    cs_ignore_a: assert property (
        $past(CHIP_SELECT_N_I) |-> !MEM_WRITE_O && !MEM_READ_O)
        else $error("memory access without select");
    wr_ack_a: assert property (
        MEM_WRITE_O |-> TRANSFER_ACK_OE_N_O ##1
        (!TRANSFER_ACK_OE_N_O && SHARED_ADDR_DATA_LINES_OE_N_O))
        else $error("write acknowledge wrong");
    rd_ack_a: assert property (
        MEM_READ_O |-> TRANSFER_ACK_OE_N_O [*2] ##1 (!TRANSFER_ACK_OE_N_O
        && !SHARED_ADDR_DATA_LINES_OE_N_O
        && SHARED_ADDR_DATA_LINES_O == $past(MEM_RDATA_I)))
        else $error("read acknowledge or data wrong");
    ack_release_a: assert property (
        CHIP_SELECT_N_I |=> TRANSFER_ACK_OE_N_O
        && SHARED_ADDR_DATA_LINES_OE_N_O)
        else $error("outputs held after deselect");
    nonmux_addr_a: assert property (
        MEM_WRITE_O && !BUS_STYLE_STRAP_I |->
        MEM_ADDR_O == $past(DEDICATED_ADDRESS_LINES_I)
        && MEM_WDATA_O == $past(SHARED_ADDR_DATA_LINES_I))
        else $error("separate bus address or data wrong");
    mux_addr_a: assert property (
        (MEM_WRITE_O || MEM_READ_O) && BUS_STYLE_STRAP_I |->
        MEM_ADDR_O == {2'h0, mux_addr_reg})
        else $error("shared bus latched address wrong");
    one_pulse_a: assert property (
        MEM_WRITE_O |=> !MEM_WRITE_O && !MEM_READ_O)
        else $error("more than one memory operation");
    cover property (MEM_WRITE_O && BUS_STYLE_STRAP_I);
    cover property (MEM_READ_O && !BUS_STYLE_STRAP_I);
    cover property (!IRQ_OE_N_O);
endmodule
bind hpp_host_port hpp_port_checker chk (.*);
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 0, rn = 0, strap = 0, sty = 0, cs_n = 1, ale = 0;
    logic drs = 1, rw = 1, ack, aoe, irq, ioe, loe, mw, mr;
    logic [9:0] ded = 10'h000, ma;
    logic [7:0] lin = 8'h00, st = 8'h00, en = 8'h00, lo, mwd, rd;
    int err_total = 0, n_compared = 0;
    always #10 clk = ~clk;
    hpp_host_port uut (.CLK_I(clk), .RESETN_I(rn), .BUS_STYLE_STRAP_I(strap),
        .STROBE_STYLE_I(sty), .CHIP_SELECT_N_I(cs_n),
        .ADDRESS_LATCH_STROBE_I(ale), .DATA_READ_STROBE_I(drs),
        .RW_WRITE_I(rw), .DEDICATED_ADDRESS_LINES_I(ded),
        .SHARED_ADDR_DATA_LINES_I(lin), .SHARED_ADDR_DATA_LINES_O(lo),
        .SHARED_ADDR_DATA_LINES_OE_N_O(loe), .TRANSFER_ACK_N_O(ack),
        .TRANSFER_ACK_OE_N_O(aoe), .IRQ_N_O(irq), .IRQ_OE_N_O(ioe),
        .INT_STATUS_I(st), .INT_ENABLE_I(en), .MEM_ADDR_O(ma),
        .MEM_WDATA_O(mwd), .MEM_WRITE_O(mw), .MEM_READ_O(mr),
        .MEM_RDATA_I(rd));
    hpp_mem_model mdl (.clk_i(clk), .write_i(mw), .read_i(mr),
        .addr_i(ma), .wdata_i(mwd), .rdata_o(rd));
    ////////////////////////////////////////////////////////////////////
    task wrap_up;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk_d(string nm, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chk_b(string nm, logic e, logic g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task strobe(logic on, logic wr);
        if (!strap) begin
            drs <= !on;
            rw <= !wr;
        end else if (!sty) begin
            drs <= on;
            rw <= !wr;
        end else begin
            drs <= !(on && !wr);
            rw <= !(on && wr);
        end
    endtask
    // Latch strobe pulsed in both modes, ignored when separate
    task acc(logic sel, logic wr, logic [9:0] a, logic [7:0] d,
             output logic [7:0] q, output logic ok);
        int n;
        @(posedge clk);
        ale <= 1'h1;
        lin <= strap ? a[7:0] : ~a[7:0];
        ded <= strap ? ~a : a;
        @(posedge clk);
        ale <= 1'h0;
        @(posedge clk);
        cs_n <= !sel;
        strobe(1'h1, wr);
        lin <= wr ? d : ~a[7:0];
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (aoe !== 1'h0 && n < 12);
        ok = (aoe === 1'h0);
        q = lo;
        chk_b("line drive", wr || !sel, loe);
        @(posedge clk);
        cs_n <= 1'h1;
        strobe(1'h0, wr);
        @(posedge clk);
    endtask
    task mode(logic m, logic s);
        strap <= m;
        sty <= s;
        @(posedge clk);
        strobe(1'h0, 1'h0);
        repeat (3) @(posedge clk);
    endtask
    task t_rw(logic m, logic s, logic [9:0] a, logic [7:0] d);
        logic [7:0] q;
        logic ok;
        mode(m, s);
        acc(1'h1, 1'h1, a, d, q, ok);
        chk_b("write ack", 1'h1, ok);
        chk_b("ack level", 1'h0, ack);
        chk_d("stored", d, mdl.mem[a]);
        acc(1'h1, 1'h0, a, 8'h00, q, ok);
        chk_b("read ack", 1'h1, ok);
        chk_d("read data", d, q);
        $display("Test rw mode %0d style %0d done", m, s);
    endtask
    task t_cross_cs;
        logic [7:0] q;
        logic ok;
        mode(1'h0, 1'h0);
        acc(1'h1, 1'h0, 10'h05C, 8'h00, q, ok);
        chk_d("cross read", 8'h5A, q);
        acc(1'h0, 1'h1, 10'h3A5, 8'h11, q, ok);
        chk_b("unselected ack", 1'h0, ok);
        chk_d("unselected kept", 8'hC3, mdl.mem[10'h3A5]);
        $display("Test cross and select done");
    endtask
    task t_irq;
        en <= 8'hAA;
        for (int i = 0; i < 8; i++) begin
            st <= 8'h01 << i;
            @(negedge clk);
            chk_b("irq", !(i % 2), ioe);
            chk_b("irq level", 1'h0, irq);
            @(posedge clk);
        end
        en <= 8'h00;
        st <= 8'hFF;
        @(negedge clk);
        chk_b("irq masked", 1'h1, ioe);
        $display("Test irq done");
    endtask
    initial begin
        #200000;
        err_total++;
        wrap_up;
    end
    initial begin
        repeat (2) @(posedge clk);
        rn <= 1'h1;
        t_rw(1'h0, 1'h0, 10'h3A5, 8'hC3);
        t_rw(1'h1, 1'h0, 10'h05C, 8'h5A);
        t_rw(1'h1, 1'h1, 10'h0A7, 8'h96);
        t_cross_cs;
        t_irq;
        wrap_up;
    end
endmodule
`default_nettype wire
